//--- src/ocsb_pkg.sv
// Constants, types and register map of one overcurrent stage block.
// Assumes a 25 MHz reference clock and a periodic processing tick.
package ocsb_pkg;
   // *****************************************************************
   // Timing
   // *****************************************************************
   localparam int unsigned REF_CLK_HZ = 25_000_000;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned MS_CYCLES = REF_CLK_HZ / MS_PER_S;
   localparam int unsigned CYCLE_MS = 5;
   localparam int unsigned PRE_TRIG_MS = 20;
   localparam int unsigned PRE_FAULT_MS = 200;
   localparam int unsigned PRE_TRIG_CYC = PRE_TRIG_MS / CYCLE_MS;
   localparam int unsigned PRE_FAULT_CYC = PRE_FAULT_MS / CYCLE_MS;
   localparam int unsigned BLOCK_LEAD_MS = 5;
   localparam int unsigned REM_MAX_S = 1800;
   localparam logic [23:0] REM_MAX_MS = 24'(REM_MAX_S * MS_PER_S);
   localparam logic [23:0] RESET_RATIO_PCT = 24'h000061;
   localparam logic [23:0] PCT_FULL = 24'h000064;
   localparam int unsigned REC_DEPTH = 12;
   localparam int unsigned MAG_W = 16;
   localparam int unsigned EV_N = 9;
   // *****************************************************************
   // Register offsets (bytes)
   // *****************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_THRESH = 8'h04;
   localparam logic [7:0] ADDR_DELAY = 8'h08;
   localparam logic [7:0] ADDR_RELEASE = 8'h0c;
   localparam logic [7:0] ADDR_HARM = 8'h10;
   localparam logic [7:0] ADDR_EVMASK = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [7:0] ADDR_IRQ_ST = 8'h1c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
   localparam logic [7:0] ADDR_CNT0 = 8'h24;
   localparam logic [7:0] ADDR_CNT1 = 8'h28;
   localparam logic [7:0] ADDR_CNT2 = 8'h2c;
   localparam logic [7:0] ADDR_REC_SEL = 8'h30;
   localparam logic [7:0] ADDR_REC_STAMP = 8'h34;
   localparam logic [7:0] ADDR_REC_INFO = 8'h38;
   localparam logic [7:0] ADDR_REC_CUR0 = 8'h3c;
   localparam logic [7:0] ADDR_REC_CUR1 = 8'h40;
   localparam logic [7:0] ADDR_REC_REM = 8'h44;
   localparam logic [7:0] ADDR_REMAIN = 8'h48;
   // *****************************************************************
   // Field positions and reset values
   // *****************************************************************
   localparam int unsigned CTRL_INVERSE_TIME_CURVE = 0;
   localparam int unsigned CTRL_INRUSH = 1;
   localparam int unsigned CTRL_CLR0 = 2;
   localparam int unsigned EVMASK_OFF_POS = 16;
   localparam logic [15:0] THRESH_RST = 16'h0078;
   localparam logic [31:0] DELAY_RST = 32'h0000_0064;
   localparam logic [15:0] RELEASE_RST = 16'h0000;
   localparam logic [15:0] HARM_RST = 16'h0001;
   localparam logic [EV_N-1:0] EVMASK_RST = 9'h1ff;
   localparam int unsigned EV_START = 0;
   localparam int unsigned EV_TRIP = 1;
   localparam int unsigned EV_BLOCK = 2;
   localparam int unsigned EV_START_A = 3;
   localparam int unsigned EV_TRIP_A = 6;
   localparam logic [1:0] REC_EV_START = 2'h1;
   localparam logic [1:0] REC_EV_TRIP = 2'h2;
   localparam logic [1:0] REC_EV_BLOCK = 2'h3;
   // *****************************************************************
   // Types
   // *****************************************************************
   typedef enum logic [1:0] {
      ST_NORMAL = 2'h0,
      ST_START = 2'h1,
      ST_TRIP = 2'h3,
      ST_BLOCKED = 2'h2
   } ocsb_state_t;
   typedef logic [2:0][MAG_W-1:0] ocsb_phase_t;
   typedef struct packed {
      logic [31:0] stamp;
      logic [1:0] evt;
      logic [2:0] phases;
      logic [2:0] group;
      logic [MAG_W-1:0] pre_trig;
      logic [MAG_W-1:0] fault;
      logic [MAG_W-1:0] pre_fault;
      logic [23:0] remain;
   } ocsb_rec_t;
endpackage : ocsb_pkg

//--- src/ocsb_stage.sv
// One overcurrent stage: pick-up, blocking, trip timing, events, counters
// and a fault record ring, with an APB register slave.
// Assumes CYCLE_TICK_I pulses once per processing cycle and that all
// inputs are synchronous to REF_CLK_I.
//
// Functional notes
// - Blocking input sampled once at cycle start; that sample rules the cycle.
// - External block comes from one dedicated binary input.
// - Pick-up without block asserts start and begins trip timing.
// - Pick-up with block active asserts blocked; no start, no timing.
// - Block after start drops start and runs release timing.
// - Optional second-harmonic inrush blocking, enable defaults off.
// - Inrush limit is harmonic/fundamental ratio in 0.01 percent steps.
// - Fixed delay and current-dependent inverse delay both supported.
// - On/off events for start, trip, block and per-phase start/trip.
// - Per-event mask chooses on, off or both events for storing.
// - Every event carries the timestamp of its status change.
// - Clearable cumulative counters for start, trip and blocked.
// - Ring of last 12 fault records, oldest overwritten.
// - Records captured only on on-transitions of start, trip, blocked.
// - Record holds stamp, event, phases, three currents, remaining time, group.
// - Phase pick-up above threshold, releases below 97 percent of it.
`timescale 1ns/1ns
`default_nettype none
module ocsb_stage
   import ocsb_pkg::*;
#(
   parameter int unsigned CYCLES_PER_MS = ocsb_pkg::MS_CYCLES
) (
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic CYCLE_TICK_I,
   input wire ocsb_pkg::ocsb_phase_t PHASE_MAG_I,
   input wire logic [15:0] HARM_RATIO_I,
   input wire logic BLOCK_I,
   input wire logic [2:0] SET_GROUP_I,
   output logic START_O,
   output logic TRIP_O,
   output logic BLOCKED_O,
   output logic [ocsb_pkg::EV_N-1:0] EVT_ON_O,
   output logic [ocsb_pkg::EV_N-1:0] EVT_OFF_O,
   output logic EVT_VALID_O,
   output logic [31:0] EVT_STAMP_O,
   output logic IRQ_O
);
   import ocsb_pkg::*;

   // *****************************************************************
   // Declarations
   // *****************************************************************
   ocsb_state_t state_q;
   logic tick_q, block_s_q, inverse_time_curve_q, inrush_en_q, wr_en, rd_setup, addr_hit;
   logic pick_any, inrush, blk_eff, rec_wr;
   logic [2:0] ph_pick_q;
   ocsb_phase_t mag_s_q;
   logic [MAG_W-1:0] imax, excess, pickup_threshold_q;
   logic [15:0] harm_s_q, harm_limit_q, release_q, rel_q;
   logic [31:0] fixed_time_delay_q, acc_q, acc_nx, ms_q, pre_q, rd_mux;
   logic [23:0] remain;
   logic [EV_N-1:0] st_vec, prev_q, on_v, off_v, mask_on_q, mask_off_q;
   logic [2:0] irq_st_q, irq_mask_q, clr_cnt;
   logic [2:0][31:0] cnt_q;
   logic [MAG_W-1:0] hist_q [PRE_FAULT_CYC];
   logic [5:0] hist_ptr_q, pre_idx;
   ocsb_rec_t ring_q [REC_DEPTH];
   ocsb_rec_t rec_rd;
   logic [3:0] wr_ptr_q, rec_cnt_q, rec_sel_q;
   logic [4:0] rd_tmp, rd_idx;

   // *****************************************************************
   // Millisecond timestamp
   // *****************************************************************
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         pre_q <= 32'h0;
         ms_q <= 32'h0;
      end else if (pre_q == 32'(CYCLES_PER_MS - 1)) begin
         pre_q <= 32'h0;
         ms_q <= ms_q + 32'h1;
      end else begin
         pre_q <= pre_q + 32'h1;
      end
   end

   // *****************************************************************
   // Cycle sampling and pick-up
   // *****************************************************************
   // Decisions run one clock after the tick, on values caught at the tick
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         tick_q <= 1'b0;
         block_s_q <= 1'b0;
         harm_s_q <= 16'h0;
         mag_s_q <= '0;
      end else begin
         tick_q <= CYCLE_TICK_I;
         if (CYCLE_TICK_I) begin
            block_s_q <= BLOCK_I;
            harm_s_q <= HARM_RATIO_I;
            mag_s_q <= PHASE_MAG_I;
         end
      end
   end

   for (genvar g = 0; g < 3; g++) begin : g_phase
      logic [23:0] mag_pct, thr_pct;
      assign mag_pct = 24'(PHASE_MAG_I[g]) * PCT_FULL;
      assign thr_pct = 24'(pickup_threshold_q) * RESET_RATIO_PCT;
      always_ff @(posedge REF_CLK_I) begin
         if (RST_I) begin
            ph_pick_q[g] <= 1'b0;
         end else if (CYCLE_TICK_I) begin
            if (PHASE_MAG_I[g] > pickup_threshold_q) begin
               ph_pick_q[g] <= 1'b1;
            end else if (mag_pct < thr_pct) begin
               ph_pick_q[g] <= 1'b0;
            end
         end
      end
   end

   always_comb begin
      imax = mag_s_q[0];
      for (int i = 1; i < 3; i++) begin
         if (mag_s_q[i] > imax) begin
            imax = mag_s_q[i];
         end
      end
   end

   assign pick_any = |ph_pick_q;
   assign inrush = inrush_en_q && pick_any && (harm_s_q >= harm_limit_q);
   assign blk_eff = block_s_q || inrush;

   // *****************************************************************
   // Stage state and trip timing
   // *****************************************************************
   // Inverse mode integrates the excess over threshold, so heavier faults trip sooner
   assign excess = (imax > pickup_threshold_q) ? imax - pickup_threshold_q : MAG_W'(1);
   assign acc_nx = acc_q + (inverse_time_curve_q ? 32'(excess) : 32'(CYCLE_MS));
   assign remain = (state_q != ST_START || acc_q >= fixed_time_delay_q) ? 24'h0 :
                   ((fixed_time_delay_q - acc_q) > 32'(REM_MAX_MS)) ? REM_MAX_MS :
                   24'(fixed_time_delay_q - acc_q);

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         state_q <= ST_NORMAL;
         acc_q <= 32'h0;
         rel_q <= 16'h0;
      end else if (tick_q) begin
         if (rel_q != 16'h0) begin
            rel_q <= (rel_q > 16'(CYCLE_MS)) ? rel_q - 16'(CYCLE_MS) : 16'h0;
            if (rel_q <= 16'(CYCLE_MS)) begin
               acc_q <= 32'h0;
            end
         end
         case (state_q)
            ST_NORMAL: begin
               if (pick_any && blk_eff) begin
                  state_q <= ST_BLOCKED;
               end else if (pick_any) begin
                  state_q <= ST_START;
                  rel_q <= 16'h0;
               end
            end
            ST_START: begin
               if (!pick_any || blk_eff) begin
                  state_q <= ST_NORMAL;
                  rel_q <= release_q;
                  if (release_q == 16'h0) begin
                     acc_q <= 32'h0;
                  end
               end else begin
                  acc_q <= acc_nx;
                  if (acc_nx >= fixed_time_delay_q) begin
                     state_q <= ST_TRIP;
                  end
               end
            end
            ST_TRIP: begin
               if (!pick_any) begin
                  state_q <= ST_NORMAL;
                  acc_q <= 32'h0;
               end
            end
            ST_BLOCKED: begin
               if (!pick_any) begin
                  state_q <= ST_NORMAL;
               end else if (!blk_eff) begin
                  state_q <= ST_START;
                  rel_q <= 16'h0;
               end
            end
            default: begin
               state_q <= ST_NORMAL;
            end
         endcase
      end
   end

   assign START_O = (state_q == ST_START);
   assign TRIP_O = (state_q == ST_TRIP);
   assign BLOCKED_O = (state_q == ST_BLOCKED);

   // *****************************************************************
   // Events, counters, interrupt
   // *****************************************************************
   assign st_vec = {(TRIP_O ? ph_pick_q : 3'h0), ((START_O || TRIP_O) ? ph_pick_q : 3'h0),
                    BLOCKED_O, TRIP_O, START_O};
   assign on_v = st_vec & ~prev_q;
   assign off_v = ~st_vec & prev_q;

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         prev_q <= '0;
         EVT_ON_O <= '0;
         EVT_OFF_O <= '0;
         EVT_VALID_O <= 1'b0;
         EVT_STAMP_O <= 32'h0;
      end else begin
         prev_q <= st_vec;
         EVT_ON_O <= on_v & mask_on_q;
         EVT_OFF_O <= off_v & mask_off_q;
         EVT_VALID_O <= |((on_v & mask_on_q) | (off_v & mask_off_q));
         EVT_STAMP_O <= ms_q;
      end
   end

   assign clr_cnt = (wr_en && PADDR_I == ADDR_CTRL) ? PWDATA_I[CTRL_CLR0 +: 3] : 3'h0;

   for (genvar c = 0; c < 3; c++) begin : g_cnt
      // An occurrence in the clearing cycle counts as the first after clear
      always_ff @(posedge REF_CLK_I) begin
         if (RST_I) begin
            cnt_q[c] <= 32'h0;
         end else if (clr_cnt[c]) begin
            cnt_q[c] <= on_v[c] ? 32'h1 : 32'h0;
         end else if (on_v[c]) begin
            cnt_q[c] <= cnt_q[c] + 32'h1;
         end
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         irq_st_q <= 3'h0;
      end else begin
         irq_st_q <= (irq_st_q & ~((wr_en && PADDR_I == ADDR_IRQ_ST) ? PWDATA_I[2:0] : 3'h0))
                     | on_v[2:0];
      end
   end
   assign IRQ_O = |(irq_st_q & irq_mask_q);

   // *****************************************************************
   // Current history and fault record ring
   // *****************************************************************
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         hist_ptr_q <= 6'h0;
      end else if (tick_q) begin
         hist_q[hist_ptr_q] <= imax;
         hist_ptr_q <= (hist_ptr_q == 6'(PRE_FAULT_CYC - 1)) ? 6'h0 : hist_ptr_q + 6'h1;
      end
   end
   // Oldest slot sits at the write pointer; pre-trigger slot a few behind it
   assign pre_idx = (hist_ptr_q >= 6'(PRE_TRIG_CYC)) ? hist_ptr_q - 6'(PRE_TRIG_CYC)
                    : hist_ptr_q + 6'(PRE_FAULT_CYC - PRE_TRIG_CYC);

   assign rec_wr = |on_v[2:0];

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         wr_ptr_q <= 4'h0;
         rec_cnt_q <= 4'h0;
      end else if (rec_wr) begin
         ring_q[wr_ptr_q] <= '{stamp: ms_q,
            evt: on_v[EV_TRIP] ? REC_EV_TRIP : on_v[EV_BLOCK] ? REC_EV_BLOCK : REC_EV_START,
            phases: ph_pick_q, group: SET_GROUP_I, pre_trig: hist_q[pre_idx], fault: imax,
            pre_fault: hist_q[hist_ptr_q], remain: remain};
         wr_ptr_q <= (wr_ptr_q == 4'(REC_DEPTH - 1)) ? 4'h0 : wr_ptr_q + 4'h1;
         if (rec_cnt_q != 4'(REC_DEPTH)) begin
            rec_cnt_q <= rec_cnt_q + 4'h1;
         end
      end
   end

   // Select 0 is the newest record
   assign rd_tmp = {1'b0, wr_ptr_q} + 5'(REC_DEPTH - 1) - {1'b0, rec_sel_q};
   assign rd_idx = (rd_tmp >= 5'(REC_DEPTH)) ? rd_tmp - 5'(REC_DEPTH) : rd_tmp;
   assign rec_rd = ring_q[rd_idx[3:0]];

   // *****************************************************************
   // APB slave
   // *****************************************************************
   assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
   assign rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_hit;

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         inverse_time_curve_q <= 1'b0;
         inrush_en_q <= 1'b0;
         pickup_threshold_q <= THRESH_RST;
         fixed_time_delay_q <= DELAY_RST;
         release_q <= RELEASE_RST;
         harm_limit_q <= HARM_RST;
         mask_on_q <= EVMASK_RST;
         mask_off_q <= EVMASK_RST;
         irq_mask_q <= 3'h0;
         rec_sel_q <= 4'h0;
      end else if (wr_en) begin
         case (PADDR_I)
            ADDR_CTRL: begin
               inverse_time_curve_q <= PWDATA_I[CTRL_INVERSE_TIME_CURVE];
               inrush_en_q <= PWDATA_I[CTRL_INRUSH];
            end
            ADDR_THRESH: pickup_threshold_q <= PWDATA_I[MAG_W-1:0];
            ADDR_DELAY: fixed_time_delay_q <= PWDATA_I;
            ADDR_RELEASE: release_q <= PWDATA_I[15:0];
            ADDR_HARM: harm_limit_q <= PWDATA_I[15:0];
            ADDR_EVMASK: begin
               mask_on_q <= PWDATA_I[EV_N-1:0];
               mask_off_q <= PWDATA_I[EVMASK_OFF_POS +: EV_N];
            end
            ADDR_IRQ_MASK: irq_mask_q <= PWDATA_I[2:0];
            ADDR_REC_SEL: begin
               rec_sel_q <= (PWDATA_I[3:0] >= 4'(REC_DEPTH)) ? 4'(REC_DEPTH - 1) : PWDATA_I[3:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      addr_hit = 1'b1;
      rd_mux = 32'h0;
      case (PADDR_I)
         ADDR_CTRL: rd_mux = {30'h0, inrush_en_q, inverse_time_curve_q};
         ADDR_THRESH: rd_mux = 32'(pickup_threshold_q);
         ADDR_DELAY: rd_mux = fixed_time_delay_q;
         ADDR_RELEASE: rd_mux = 32'(release_q);
         ADDR_HARM: rd_mux = 32'(harm_limit_q);
         ADDR_EVMASK: rd_mux = {7'h0, mask_off_q, 7'h0, mask_on_q};
         ADDR_STATUS: rd_mux = {19'h0, blk_eff, inrush, ph_pick_q, st_vec[EV_N-1:3], state_q};
         ADDR_IRQ_ST: rd_mux = 32'(irq_st_q);
         ADDR_IRQ_MASK: rd_mux = 32'(irq_mask_q);
         ADDR_CNT0: rd_mux = cnt_q[0];
         ADDR_CNT1: rd_mux = cnt_q[1];
         ADDR_CNT2: rd_mux = cnt_q[2];
         ADDR_REC_SEL: rd_mux = {20'h0, rec_cnt_q, 4'h0, rec_sel_q};
         ADDR_REC_STAMP: rd_mux = rec_rd.stamp;
         ADDR_REC_INFO: rd_mux = {24'h0, rec_rd.group, rec_rd.phases, rec_rd.evt};
         ADDR_REC_CUR0: rd_mux = {rec_rd.fault, rec_rd.pre_trig};
         ADDR_REC_CUR1: rd_mux = 32'(rec_rd.pre_fault);
         ADDR_REC_REM: rd_mux = 32'(rec_rd.remain);
         ADDR_REMAIN: rd_mux = 32'(remain);
         default: addr_hit = 1'b0;
      endcase
   end

   // Read data is caught in the setup phase so it stands from a flip-flop
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         PRDATA_O <= 32'h0;
      end else if (rd_setup) begin
         PRDATA_O <= rd_mux;
      end
   end

   // *****************************************************************
   // Assertions
   // *****************************************************************
   a_block_sample_hold: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      !CYCLE_TICK_I |=> $stable(block_s_q)) else $error("block sample moved outside tick");
   a_start_on_pick: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      tick_q && state_q == ST_NORMAL && pick_any && !blk_eff |=> state_q == ST_START)
      else $error("pick-up without block did not start");
   a_blocked_on_pick: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      tick_q && state_q == ST_NORMAL && pick_any && blk_eff |=> BLOCKED_O && !START_O)
      else $error("pick-up with block did not give blocked");
   a_block_drops_start: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      tick_q && START_O && blk_eff |=> !START_O && rel_q == $past(release_q))
      else $error("block after start did not release");
   a_inrush_gated: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      !inrush_en_q |-> !inrush) else $error("inrush block while disabled");
   a_fixed_trip: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      tick_q && START_O && !blk_eff && pick_any && !inverse_time_curve_q
      && acc_q + 32'(CYCLE_MS) >= fixed_time_delay_q |=> TRIP_O)
      else $error("fixed delay did not trip");
   a_event_mask: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      ##1 (EVT_ON_O & ~$past(mask_on_q)) == '0 && (EVT_OFF_O & ~$past(mask_off_q)) == '0)
      else $error("masked event reached output");
   a_event_stamp: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      EVT_VALID_O |-> EVT_STAMP_O == $past(ms_q)) else $error("event stamp wrong");
   a_counter_clear: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      clr_cnt[0] && !on_v[0] |=> cnt_q[0] == 32'h0) else $error("counter not cleared");
   a_ring_full: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      rec_wr && rec_cnt_q == 4'(REC_DEPTH) |=> rec_cnt_q == 4'(REC_DEPTH) && $changed(wr_ptr_q))
      else $error("full ring did not overwrite");
   a_record_on_only: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      $changed(wr_ptr_q) |-> $past(on_v[2:0]) != 3'h0) else $error("record without on event");
   a_state_legal: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      $onehot({START_O, TRIP_O, BLOCKED_O, state_q == ST_NORMAL}))
      else $error("stage status not one state");
endmodule : ocsb_stage
`default_nettype wire

//--- testbench/ocsb_far_side.sv
// Far-side model: phase comparator feed and blocking matrix.
// Assumes the bench sets the fault level and the block request.
`timescale 1ns/1ns
`default_nettype none
module ocsb_far_side
   import ocsb_pkg::*;
(
   input wire logic clk_i,
   input wire logic level_en_i,
   input wire logic [15:0] level_i,
   input wire logic block_i,
   output logic tick_o = 1'b0,
   output ocsb_pkg::ocsb_phase_t mag_o = '0,
   output logic block_o = 1'b0
);
   logic [2:0] div_q = 3'h0;
   // Tick every 8 clocks, above the 3-clock minimum spacing
   always_ff @(posedge clk_i) begin
      div_q <= div_q + 3'h1;
      tick_o <= div_q == 3'h7;
   end
   // Inputs move mid-cycle only, so a block lands well before expiry
   always_ff @(posedge clk_i) begin
      if (div_q == 3'h3) begin
         block_o <= block_i;
         mag_o <= {16'h0010, 16'h0010, level_en_i ? level_i : 16'h0000};
      end
   end
endmodule : ocsb_far_side
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench of one overcurrent stage over APB.
// Assumes the far-side model supplies tick, magnitudes and block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import ocsb_pkg::*;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, blk = 1'b0, serr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd, prdata, stamp;
   logic [15:0] lvl = 16'h0000, harm = 16'h0000;
   logic tick, blk_o, pready, pslverr, st, tr, bl, evv, irq;
   logic [8:0] eon, eoff, seen = 9'h000, seen_off = 9'h000;
   ocsb_phase_t mag;
   int failures = 0, tests_run = 0, cyc = 0;
   initial forever #20 clk = ~clk;
   always @(posedge clk) cyc <= rst ? 0 : cyc + 1;
   // Sampled mid-cycle, clear of the edge that launches the event pulses
   always @(negedge clk) begin
      if (evv === 1'b1) begin
         seen = seen | eon;
         seen_off = seen_off | eoff;
         chk(stamp, 32'((cyc - 1) / 4));
      end
   end
   ocsb_far_side u_far (.clk_i(clk), .level_en_i(1'b1), .level_i(lvl), .block_i(blk), .tick_o(tick),
      .mag_o(mag), .block_o(blk_o));
   ocsb_stage #(.CYCLES_PER_MS(4)) u_dut (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .CYCLE_TICK_I(tick), .PHASE_MAG_I(mag), .HARM_RATIO_I(harm),
      .BLOCK_I(blk_o), .SET_GROUP_I(3'h2), .START_O(st), .TRIP_O(tr), .BLOCKED_O(bl),
      .EVT_ON_O(eon), .EVT_OFF_O(eoff), .EVT_VALID_O(evv), .EVT_STAMP_O(stamp), .IRQ_O(irq));
   // ****************************************
   // Access and check tasks
   // ****************************************
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         failures++;
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin failures++; complete_run(); end
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0; pen <= 1'b0;
      @(posedge clk);
   endtask : apb
   // State 0 start, 1 trip, 2 blocked, 3 normal; bounded wait
   task automatic wt(input int s);
      int n;
      n = 0;
      while ({st, tr, bl} !== (s == 3 ? 3'b000 : 3'b100 >> s) && n < 600) begin @(posedge clk); n++; end
      tests_run++;
      if (n >= 600) begin failures++; complete_run(); end
   endtask : wt
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(0, ADDR_THRESH, 0); chk(rd, 32'h78);
      apb(0, ADDR_DELAY, 0); chk(rd, 32'h64);
      apb(0, 8'hfc, 0); chk(rd, 32'h0); chk(serr, 1'b1);
      apb(0, ADDR_CTRL, 0); chk(rd, 32'h0);
      apb(0, ADDR_HARM, 0); chk(rd, 32'h1);
      seen = 9'h000; lvl <= 16'h0100;
      wt(0);
      repeat (3) @(posedge clk); chk(seen, 9'h009);
      apb(0, ADDR_STATUS, 0); chk(rd[1:0], 2'h1);
      apb(0, ADDR_REC_INFO, 0); chk(rd[7:0], 8'h45);
      apb(1, ADDR_IRQ_MASK, 1); chk(irq, 1'b1);
      apb(1, ADDR_IRQ_ST, 1); chk(irq, 1'b0);
      wt(1);
      apb(0, ADDR_CNT1, 0); chk(rd, 32'h1);
      lvl <= 16'h0000;
      wt(3);
      apb(0, ADDR_REC_SEL, 0); chk(rd[11:8], 4'h2);
      blk <= 1'b1; lvl <= 16'h0100;
      wt(2); chk(st, 1'b0);
      apb(0, ADDR_CNT2, 0); chk(rd, 32'h1);
      blk <= 1'b0;
      wt(0);
      blk <= 1'b1;
      wt(3);
      wt(2);
      blk <= 1'b0; lvl <= 16'h0000;
      wt(3);
      apb(1, ADDR_THRESH, 32'h64);
      lvl <= 16'h0065;
      wt(0);
      lvl <= 16'h0062;
      repeat (40) @(posedge clk); chk(st, 1'b1);
      lvl <= 16'h0060;
      wt(3);
      apb(1, ADDR_CTRL, 32'h4); apb(0, ADDR_CNT0, 0); chk(rd, 32'h0);
      apb(1, ADDR_EVMASK, 32'h01ff0000);
      seen = 9'h000; lvl <= 16'h0100;
      wt(0);
      repeat (3) @(posedge clk); chk(seen, 9'h000);
      seen_off = 9'h000; lvl <= 16'h0000;
      wt(3);
      repeat (3) @(posedge clk); chk(seen_off, 9'h009);
      // Long fixed delay would time out; only the inverse curve trips in time
      apb(1, ADDR_DELAY, 32'h190); apb(1, ADDR_CTRL, 32'h1);
      lvl <= 16'h0100;
      wt(1);
      lvl <= 16'h0000;
      wt(3);
      apb(1, ADDR_CTRL, 32'h2); apb(1, ADDR_HARM, 32'h5dc);
      harm <= 16'h07d0; lvl <= 16'h0100;
      wt(2);
      repeat (3) begin
         lvl <= 16'h0000;
         wt(3);
         lvl <= 16'h0100;
         wt(2);
      end
      apb(0, ADDR_REC_SEL, 0); chk(rd[11:8], 4'hc);
      apb(0, ADDR_REC_INFO, 0); chk(rd[7:0], 8'h47);
      complete_run();
   end
endmodule : testbench
`default_nettype wire
